// ==== hw/lupp_pkg.sv ====
// Constants, register map and types of the user command port.
package lupp_pkg;

  // Register byte offsets on the bus, decoded from address bits 3:0.
  localparam int ADDR_W = 4;
  localparam logic [3:0] CSR_ADDR = 4'h0;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'h4;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;
  localparam logic [3:0] PHASE_ADDR = 4'hc;

  // Field positions inside the command control and status register.
  localparam int ERR_BIT = 15;
  localparam int AVAIL_BIT = 14;
  localparam int PARAM_BIT = 13;
  localparam int CODE_HI = 12;
  localparam int CODE_LO = 8;
  localparam int CODE_W = 5;
  localparam int HIGH_LANE = 1;
  localparam int LOW_LANE = 0;

  // Command codes.
  localparam logic [4:0] CMD_STOP = 5'h00;
  localparam logic [4:0] CMD_START = 5'h01;
  localparam logic [4:0] CMD_TRANS = 5'h03;
  localparam logic [4:0] CMD_CONN_REQ = 5'h06;
  localparam logic [4:0] CMD_CONN_RSP = 5'h07;
  localparam logic [4:0] CMD_RST_REQ = 5'h08;
  localparam logic [4:0] CMD_RST_RSP = 5'h09;

  // Interrupt status and mask layout.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_COUNT = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Idle pattern sent between frames while the link is running.
  localparam logic [7:0] FLAG_PATTERN = 8'h7e;

  // Operating phase of the controller.
  typedef enum logic [1:0] {
    phase_stopped,
    phase_disconnected,
    phase_connected,
    phase_transparent
  } lupp_phase_type;

endpackage

// ==== hw/lupp_sticky_flag.sv ====
// Sticky flag that hardware sets and software clears.
`timescale 1ns/100ps
module lupp_sticky_flag (
  input wire logic clock,
  input wire logic reset,
  input wire logic set_event,
  input wire logic clear_request,
  output logic flag
);

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clock) begin
    if (reset) begin
      flag <= 1'b0;
    end else begin
      flag <= set_event | (flag & ~clear_request);
    end
  end

endmodule

// ==== hw/lupp_tx_line.sv ====
// Serial transmit line driver: ones when stopped, flags or frame bits.
`timescale 1ns/100ps
module lupp_tx_line (
  input wire logic clock,
  input wire logic reset,
  input wire logic hold_ones,
  input wire logic frame_active,
  input wire logic frame_bit,
  output logic tx_line
);

  logic [7:0] flag_shift;

  // The flag pattern rotates so idle time is filled with whole flags.
  always_ff @(posedge clock) begin
    if (reset || hold_ones) begin
      flag_shift <= lupp_pkg::FLAG_PATTERN;
    end else if (!frame_active) begin
      flag_shift <= {flag_shift[0], flag_shift[7:1]};
    end
  end

  // Holding ones overrides a frame in flight, which aborts it on the line.
  always_ff @(posedge clock) begin
    if (reset || hold_ones) begin
      tx_line <= 1'b1;
    end else if (frame_active) begin
      tx_line <= frame_bit;
    end else begin
      tx_line <= flag_shift[0];
    end
  end

endmodule

// ==== hw/lupp_command_port.sv ====
// User command port with classic Wishbone register access.
//
// How it works
// - Conflicting command sets the error flag.
// - Error flag clears only by written one.
// - Available flag set by host, cleared after processing.
// - Stop: stopped phase, no DMA, ones, no receive.
// - Stop during a frame aborts it with ones.
// - Stop with parameter one resets whole device.
// - Start zero: disconnected, ring reset, flags sent.
// - Start one: straight to connected phase.
// - Start valid only when stopped or transparent.
`timescale 1ns/100ps
module lupp_command_port (
  input wire logic clock,
  input wire logic reset,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdata,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  input wire logic tx_frame_active,
  input wire logic tx_frame_bit,
  output logic tx_line,
  output logic dma_enable,
  output logic receive_enable,
  output logic [1:0] link_phase,
  output logic ring_pointer_reset,
  output logic retransmit_unacked,
  output logic descriptor_owner_release,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  lupp_pkg::lupp_phase_type phase;
  lupp_pkg::lupp_phase_type next_phase;
  logic soft_reset;
  logic core_reset;
  logic command_available_flag;
  logic command_error_flag;
  logic command_parameter;
  logic [4:0] command_code;
  logic accepted;
  logic want_soft;
  logic want_ring;
  logic want_retx;
  logic want_discard;
  logic access;
  logic write_csr;
  logic write_status;
  logic write_mask;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  logic [1:0] irq_clear;

  // A soft reset acts one cycle after the Stop is taken, like the pin.
  assign core_reset = reset | soft_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.
  assign access = wb_cyc & wb_stb;
  assign write_csr = access & wb_we & wb_ack & (wb_adr == lupp_pkg::CSR_ADDR)
                     & wb_sel[lupp_pkg::HIGH_LANE];
  assign write_status = access & wb_we & wb_ack
                        & (wb_adr == lupp_pkg::IRQ_STATUS_ADDR)
                        & wb_sel[lupp_pkg::LOW_LANE];
  assign write_mask = access & wb_we & wb_ack
                      & (wb_adr == lupp_pkg::IRQ_MASK_ADDR)
                      & wb_sel[lupp_pkg::LOW_LANE];

  // Ack one cycle after the strobe; writes act at the edge that sees ack.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= access & ~wb_ack;
    end
  end

  // Read data is loaded at the edge that raises ack; unmapped reads zero.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      wb_rdata <= 32'h0;
    end else if (access && !wb_ack) begin
      unique case (wb_adr)
        lupp_pkg::CSR_ADDR: begin
          wb_rdata <= {16'h0, command_error_flag, command_available_flag,
                       command_parameter, command_code, 8'h00};
        end
        lupp_pkg::IRQ_STATUS_ADDR: begin
          wb_rdata <= {30'h0, irq_status};
        end
        lupp_pkg::IRQ_MASK_ADDR: begin
          wb_rdata <= {30'h0, irq_mask};
        end
        lupp_pkg::PHASE_ADDR: begin
          wb_rdata <= {30'h0, phase};
        end
        default: begin
          wb_rdata <= 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command capture.
  // A new command is only taken while the previous one is not pending.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      command_available_flag <= 1'b0;
      command_parameter <= 1'b0;
      command_code <= lupp_pkg::CMD_STOP;
    end else if (write_csr && wb_wdata[lupp_pkg::AVAIL_BIT]
                 && !command_available_flag) begin
      command_available_flag <= 1'b1;
      command_parameter <= wb_wdata[lupp_pkg::PARAM_BIT];
      command_code <= wb_wdata[lupp_pkg::CODE_HI:lupp_pkg::CODE_LO];
    end else begin
      command_available_flag <= 1'b0;
    end
  end

  // Error flag: set by a conflict, cleared only by a written one.
  lupp_sticky_flag u_error_flag (
    .clock(clock),
    .reset(core_reset),
    .set_event(command_available_flag & ~accepted),
    .clear_request(write_csr & wb_wdata[lupp_pkg::ERR_BIT]),
    .flag(command_error_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  // The parameter only matters where a code gives it a meaning.
  always_comb begin
    next_phase = phase;
    accepted = 1'b1;
    want_soft = 1'b0;
    want_ring = 1'b0;
    want_retx = 1'b0;
    want_discard = 1'b0;
    unique case (command_code)
      lupp_pkg::CMD_STOP: begin
        next_phase = lupp_pkg::phase_stopped;
        want_soft = command_parameter;
      end
      lupp_pkg::CMD_START: begin
        if (phase == lupp_pkg::phase_stopped
            || phase == lupp_pkg::phase_transparent) begin
          want_ring = 1'b1;
          if (command_parameter) begin
            next_phase = lupp_pkg::phase_connected;
          end else begin
            next_phase = lupp_pkg::phase_disconnected;
          end
        end else begin
          accepted = 1'b0;
        end
      end
      lupp_pkg::CMD_TRANS: begin
        next_phase = lupp_pkg::phase_transparent;
      end
      lupp_pkg::CMD_CONN_REQ, lupp_pkg::CMD_CONN_RSP: begin
        if (phase == lupp_pkg::phase_disconnected) begin
          want_retx = ~command_parameter;
          want_discard = command_parameter;
        end else begin
          accepted = 1'b0;
        end
      end
      lupp_pkg::CMD_RST_REQ, lupp_pkg::CMD_RST_RSP: begin
        if (phase == lupp_pkg::phase_stopped) begin
          accepted = 1'b0;
        end else if (phase == lupp_pkg::phase_connected) begin
          want_retx = ~command_parameter;
          want_discard = command_parameter;
        end
      end
      default: begin
        accepted = 1'b1;
      end
    endcase
  end

  // A rejected command leaves the phase alone.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      phase <= lupp_pkg::phase_stopped;
    end else if (command_available_flag && accepted) begin
      phase <= next_phase;
    end
  end

  // The soft reset lasts one cycle; only the pin, not the soft reset itself, resets this register.
  always_ff @(posedge clock) begin
    if (reset) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= command_available_flag & want_soft;
    end
  end

  // One-cycle pulses to the DMA and ring logic.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      ring_pointer_reset <= 1'b0;
      retransmit_unacked <= 1'b0;
      descriptor_owner_release <= 1'b0;
    end else begin
      ring_pointer_reset <= command_available_flag & accepted & want_ring;
      retransmit_unacked <= command_available_flag & accepted & want_retx;
      descriptor_owner_release <= command_available_flag & accepted
                                  & want_discard;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase outputs and line.
  assign dma_enable = phase != lupp_pkg::phase_stopped;
  assign receive_enable = phase != lupp_pkg::phase_stopped;
  assign link_phase = phase;

  lupp_tx_line u_tx_line (
    .clock(clock),
    .reset(core_reset),
    .hold_ones(phase == lupp_pkg::phase_stopped),
    .frame_active(tx_frame_active),
    .frame_bit(tx_frame_bit),
    .tx_line(tx_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.
  assign irq_set[lupp_pkg::IRQ_DONE] = command_available_flag & accepted;
  assign irq_set[lupp_pkg::IRQ_ERROR] = command_available_flag & ~accepted;
  assign irq_clear = {2{write_status}} & wb_wdata[1:0];

  // One sticky bit per event; a set beats a simultaneous clear.
  genvar g;
  generate
    for (g = 0; g < lupp_pkg::IRQ_COUNT; g++) begin : gen_irq
      lupp_sticky_flag u_irq_flag (
        .clock(clock),
        .reset(core_reset),
        .set_event(irq_set[g]),
        .clear_request(irq_clear[g]),
        .flag(irq_status[g])
      );
    end
  endgenerate

  // Mask register; a one enables the matching status bit.
  always_ff @(posedge clock) begin
    if (core_reset) begin
      irq_mask <= lupp_pkg::IRQ_MASK_RESET;
    end else if (write_mask) begin
      irq_mask <= wb_wdata[1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (core_reset);

  chk_err_on_conflict: assert property (
    command_available_flag && !accepted |=> command_error_flag)
    else $error("conflict did not set error flag");

  chk_err_stays_set: assert property (
    command_error_flag && !(write_csr && wb_wdata[lupp_pkg::ERR_BIT])
    |=> command_error_flag)
    else $error("error flag dropped without a written one");

  chk_avail_one_cycle: assert property (
    command_available_flag |=> !command_available_flag)
    else $error("available flag not cleared after processing");

  chk_unacked_retx: assert property (
    command_available_flag && accepted && want_retx
    |=> retransmit_unacked && !descriptor_owner_release)
    else $error("resend not requested for parameter zero");

  chk_unacked_discard: assert property (
    command_available_flag && accepted && want_discard
    |=> descriptor_owner_release && !retransmit_unacked)
    else $error("descriptors not released for parameter one");

  chk_stop_halts: assert property (
    command_available_flag && command_code == lupp_pkg::CMD_STOP
    && !command_parameter |=> !dma_enable && !receive_enable ##1 tx_line)
    else $error("stop did not halt dma and line");

  chk_stopped_ones: assert property (
    (phase == lupp_pkg::phase_stopped) [*2] |-> tx_line)
    else $error("line not held at ones while stopped");

  chk_soft_reset: assert property (
    command_available_flag && command_code == lupp_pkg::CMD_STOP
    && command_parameter |=> soft_reset)
    else $error("stop with parameter one did not reset");

  chk_start_disc: assert property (
    command_available_flag && accepted && command_code == lupp_pkg::CMD_START
    && !command_parameter
    |=> phase == lupp_pkg::phase_disconnected && ring_pointer_reset)
    else $error("start did not enter disconnected phase");

  chk_start_conn: assert property (
    command_available_flag && accepted && command_code == lupp_pkg::CMD_START
    && command_parameter |=> phase == lupp_pkg::phase_connected)
    else $error("start with parameter one did not connect");

  chk_start_reject: assert property (
    command_available_flag && command_code == lupp_pkg::CMD_START
    && (phase == lupp_pkg::phase_disconnected
        || phase == lupp_pkg::phase_connected)
    |=> $stable(phase) && command_error_flag && !command_available_flag)
    else $error("start in a running phase was not rejected");

  cov_start_ok: cover property (
    command_available_flag && accepted && command_code == lupp_pkg::CMD_START);
  cov_conflict: cover property (command_available_flag && !accepted);
  cov_soft_reset: cover property (disable iff (reset) soft_reset);
  cov_irq: cover property (irq);

endmodule

// ==== sim/tb_link_user_primitive_port.sv ====
// Self-checking bench for the user command port over classic Wishbone.
`timescale 1ns/100ps
module tb_link_user_primitive_port;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdata = 32'h0;
  logic tx_frame_active = 1'b0;
  logic tx_frame_bit = 1'b1;
  logic [31:0] wb_rdata;
  logic wb_ack;
  logic tx_line;
  logic dma_enable;
  logic receive_enable;
  logic [1:0] link_phase;
  logic ring_pointer_reset;
  logic retransmit_unacked;
  logic descriptor_owner_release;
  logic irq;
  logic [31:0] rd;
  logic [2:0] pulses;
  int error_cnt = 0;
  int checks = 0;
  int cycle_cnt = 0;
  int zeros;

  lupp_command_port i_dut (
    .clock(clock),
    .reset(reset),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_adr(wb_adr),
    .wb_sel(wb_sel),
    .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata),
    .wb_ack(wb_ack),
    .tx_frame_active(tx_frame_active),
    .tx_frame_bit(tx_frame_bit),
    .tx_line(tx_line),
    .dma_enable(dma_enable),
    .receive_enable(receive_enable),
    .link_phase(link_phase),
    .ring_pointer_reset(ring_pointer_reset),
    .retransmit_unacked(retransmit_unacked),
    .descriptor_owner_release(descriptor_owner_release),
    .irq(irq)
  );

  // Free-running system clock, 5 ns period.
  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // The whole run needs about 150 cycles, so a hang is cut at 5000.
  always @(posedge clock) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      $display("MISMATCH at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb_io(input logic we, input logic [3:0] adr,
                       input logic [3:0] sel, input logic [31:0] data);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdata <= data;
    do @(posedge clock); while (wb_ack !== 1'b1);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  // Reads a register and compares the bits under the mask.
  task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp,
                       input logic [31:0] mask, input string what);
    wb_io(1'b0, adr, 4'hf, 32'h0);
    chk(rd & mask, exp, what);
  endtask

  // Issues a command and captures the pulses of the processing cycle.
  task automatic issue(input logic [4:0] code, input logic param);
    wb_io(1'b1, lupp_pkg::CSR_ADDR, 4'h2,
          {16'h0, 2'b01, param, code, 8'h00});
    @(posedge clock);
    @(posedge clock);
    pulses = {ring_pointer_reset, retransmit_unacked,
              descriptor_owner_release};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; connect and reset cases come in pairs, param 0 then 1.
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rdchk(lupp_pkg::CSR_ADDR, 32'h0, 32'hffffffff, "csr reset");
    rdchk(lupp_pkg::IRQ_MASK_ADDR, 32'h0, 32'h3, "mask reset");
    rdchk(lupp_pkg::PHASE_ADDR, 32'h0, 32'h3, "phase reset");
    rdchk(4'h2, 32'h0, 32'hffffffff, "unmapped read");
    chk(32'(tx_line), 32'h1, "ones when stopped");
    chk(32'({dma_enable, receive_enable}), 32'h0, "idle");
    $display("Test reset finished at %0t", $time);
    issue(lupp_pkg::CMD_START, 1'b0);
    chk(32'(link_phase), 32'h1, "start phase");
    chk(32'(pulses), 32'h4, "ring reset");
    chk(32'({dma_enable, receive_enable}), 32'h3, "running");
    rdchk(lupp_pkg::CSR_ADDR, 32'h0, 32'hc000, "avail done");
    repeat (8) @(posedge clock);
    zeros = 0;
    repeat (16) begin
      @(posedge clock);
      if (tx_line === 1'b0) zeros++;
    end
    chk(32'(zeros), 32'h4, "flag zeros");
    $display("Test start finished at %0t", $time);
    issue(lupp_pkg::CMD_START, 1'b0);
    chk(32'(link_phase), 32'h1, "reject keeps");
    rdchk(lupp_pkg::CSR_ADDR, 32'h8000, 32'hc000, "err");
    rdchk(lupp_pkg::IRQ_STATUS_ADDR, 32'h2, 32'h2, "rej irq");
    wb_io(1'b1, lupp_pkg::CSR_ADDR, 4'h2, 32'h0);
    rdchk(lupp_pkg::CSR_ADDR, 32'h8000, 32'h8000, "w0 keeps");
    wb_io(1'b1, lupp_pkg::CSR_ADDR, 4'h2, 32'h8000);
    rdchk(lupp_pkg::CSR_ADDR, 32'h0, 32'h8000, "w1 clears");
    $display("Test reject finished at %0t", $time);
    issue(lupp_pkg::CMD_CONN_REQ, 1'b0);
    chk(32'(pulses), 32'h2, "conn resend");
    issue(lupp_pkg::CMD_CONN_RSP, 1'b1);
    chk(32'(pulses), 32'h1, "conn release");
    wb_io(1'b1, lupp_pkg::IRQ_MASK_ADDR, 4'h1, 32'h1);
    @(posedge clock);
    chk(32'(irq), 32'h1, "irq raised");
    wb_io(1'b1, lupp_pkg::IRQ_STATUS_ADDR, 4'h1, 32'h3);
    @(posedge clock);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("Test connect finished at %0t", $time);
    issue(lupp_pkg::CMD_TRANS, 1'b0);
    chk(32'(link_phase), 32'h3, "transparent");
    issue(lupp_pkg::CMD_START, 1'b1);
    chk(32'(link_phase), 32'h2, "start one");
    issue(lupp_pkg::CMD_RST_REQ, 1'b0);
    chk(32'(pulses), 32'h2, "reset resend");
    issue(lupp_pkg::CMD_RST_RSP, 1'b1);
    chk(32'(pulses), 32'h1, "reset release");
    $display("Test connected finished at %0t", $time);
    tx_frame_active <= 1'b1;
    tx_frame_bit <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(tx_line), 32'h0, "frame bit");
    issue(lupp_pkg::CMD_STOP, 1'b0);
    @(posedge clock);
    chk(32'(tx_line), 32'h1, "abort ones");
    chk(32'(link_phase), 32'h0, "stopped");
    chk(32'({dma_enable, receive_enable}), 32'h0, "halted");
    tx_frame_active <= 1'b0;
    issue(lupp_pkg::CMD_RST_REQ, 1'b0);
    rdchk(lupp_pkg::CSR_ADDR, 32'h8000, 32'h8000, "stop err");
    $display("Test stop finished at %0t", $time);
    issue(lupp_pkg::CMD_START, 1'b0);
    chk(32'(irq), 32'h1, "irq before");
    issue(lupp_pkg::CMD_STOP, 1'b1);
    rdchk(lupp_pkg::CSR_ADDR, 32'h0, 32'hffffffff, "soft csr");
    rdchk(lupp_pkg::IRQ_MASK_ADDR, 32'h0, 32'h3, "soft mask");
    rdchk(lupp_pkg::IRQ_STATUS_ADDR, 32'h0, 32'h3, "soft st");
    chk(32'({irq, link_phase}), 32'h0, "soft phase");
    $display("Test soft reset finished at %0t", $time);
    report_and_stop();
  end
endmodule
